// File: include/rtc_pkg.sv
// Package for the seconds and alarm unit: widths, timing counts and reset values.
// Assumes a 250 MHz system clock and a 32.768 kHz time base arriving on a pin.
package rtc_pkg;
	localparam int unsigned SYS_CLK_MHZ = 250;
	localparam int unsigned TIMEBASE_HZ = 32768;
	localparam int unsigned TICKS_PER_SEC = 4096;
	localparam int unsigned TICK_BITS = 12;
	localparam int unsigned SEC_BITS = 32;
	localparam int unsigned PRESCALE = TIMEBASE_HZ / TICKS_PER_SEC;
	localparam int unsigned PRESCALE_BITS = 3;
	localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE - 1);
	localparam logic [11:0] TICK_LAST = 12'h0fff;
	localparam int unsigned ALARM_MIN_S = 1;
	localparam int unsigned ALARM_MAX_S = 12 * 24 * 3600;
	localparam int unsigned TRIM_MAX_PPM = 127;
	localparam int unsigned TRIM_BITS = 8;
	localparam int unsigned PPM_PERIOD = 1000000;
	localparam logic [19:0] PPM_PERIOD_LAST = 20'hf_423f;
	localparam logic [31:0] SEC_RESET = 32'h0000_0000;
	typedef enum logic {SRC_CRYSTAL, SRC_EXTERNAL} src_e;
	typedef logic [SEC_BITS-1:0] sec_t;
endpackage

// File: include/rtc_tick_if.sv
// Interface carrying the tick events from the time base prescaler to the top.
// Assumes a single system clock domain on both sides.
interface rtc_tick_if;
	logic tick;
	logic sqw;
	modport src (output tick, output sqw);
	modport dst (input tick, input sqw);
endinterface

// File: src/rtc_seconds_alarm_unit.sv
// Seconds counter with time-of-day and sub-second alarms, trim and square-wave out.
// Assumes a 32.768 kHz crystal or external clock on a pin and a 250 MHz system clock.
module rtc_seconds_alarm_unit
	import rtc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_xtal_clk,
	input wire logic i_ext_clk,
	input wire rtc_pkg::src_e i_src_sel,
	input wire logic i_enable,
	input wire logic signed [rtc_pkg::TRIM_BITS-1:0] i_trim_ppm,
	input wire logic i_sec_load,
	input wire rtc_pkg::sec_t i_sec_value,
	input wire logic i_tod_arm,
	input wire logic [31:0] i_tod_delta,
	input wire logic i_tod_recur,
	input wire logic i_tod_int_en,
	input wire logic i_tod_wake_en,
	input wire logic i_sub_arm,
	input wire logic [31:0] i_sub_period,
	input wire logic i_sub_recur,
	input wire logic i_sub_int_en,
	input wire logic i_sub_wake_en,
	input wire logic i_alarm_clear,
	input wire logic i_sqw_en,
	output logic [31:0] o_seconds,
	output logic [11:0] o_subsec,
	output logic o_tod_flag,
	output logic o_sub_flag,
	output logic o_irq,
	output logic o_wake,
	output logic o_square_wave_out,
	output logic o_tod_reject
);
	import rtc_pkg::*;

	logic [1:0] xtal_sync, next_xtal_sync;
	logic [1:0] ext_sync, next_ext_sync;
	logic src_level, src_prev, next_src_prev;
	logic edge_seen;
	rtc_tick_if tb();

	logic [31:0] seconds, next_seconds;
	logic [11:0] subsec, next_subsec;
	logic [31:0] tod_target, next_tod_target;
	logic [31:0] tod_delta, next_tod_delta;
	logic tod_armed, next_tod_armed;
	logic [31:0] sub_count, next_sub_count;
	logic [31:0] sub_period, next_sub_period;
	logic sub_armed, next_sub_armed;
	logic tod_flag, next_tod_flag;
	logic sub_flag, next_sub_flag;
	logic irq, next_irq;
	logic wake, next_wake;
	logic sqw, next_sqw;
	logic tod_reject, next_tod_reject;
	logic sec_step, tod_hit, sub_hit;

	function automatic logic delta_ok(input logic [31:0] d);
		return d >= 32'(ALARM_MIN_S) && d <= 32'(ALARM_MAX_S);
	endfunction

	// Each pin has its own two-stage synchroniser, so the select mux only sees settled levels.
	// Switching the source may present one extra edge, so the next tick can come early.
	always_comb begin
		next_xtal_sync = {xtal_sync[0], i_xtal_clk};
		next_ext_sync = {ext_sync[0], i_ext_clk};
		src_level = (i_src_sel == SRC_EXTERNAL) ? ext_sync[1] : xtal_sync[1];
		next_src_prev = src_level;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			xtal_sync <= '0;
			ext_sync <= '0;
			src_prev <= 1'b0;
		end else begin
			xtal_sync <= next_xtal_sync;
			ext_sync <= next_ext_sync;
			src_prev <= next_src_prev;
		end
	end

	assign edge_seen = src_level & ~src_prev & i_enable;

	rtc_timebase u_timebase (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_edge(edge_seen),
		.i_trim_ppm(i_trim_ppm),
		.tb(tb.src)
	);

	assign sec_step = tb.tick && subsec == TICK_LAST;
	assign tod_hit = tod_armed && sec_step && (seconds + 32'h0000_0001) == tod_target;
	assign sub_hit = sub_armed && tb.tick && sub_count == 32'h0000_0001;

	always_comb begin
		next_seconds = seconds;
		next_subsec = subsec;
		next_tod_target = tod_target;
		next_tod_delta = tod_delta;
		next_tod_armed = tod_armed;
		next_sub_count = sub_count;
		next_sub_period = sub_period;
		next_sub_armed = sub_armed;
		next_tod_flag = tod_flag;
		next_sub_flag = sub_flag;
		next_tod_reject = 1'b0;
		if (tb.tick) begin
			next_subsec = subsec + 12'h001;
		end
		if (sec_step) begin
			next_seconds = seconds + 32'h0000_0001;
		end
		if (i_sec_load) begin
			next_seconds = i_sec_value;
			next_subsec = '0;
		end
		if (i_tod_arm) begin
			if (delta_ok(i_tod_delta)) begin
				next_tod_target = seconds + i_tod_delta;
				next_tod_delta = i_tod_delta;
				next_tod_armed = 1'b1;
			end else begin
				next_tod_reject = 1'b1;
			end
		end else if (tod_hit) begin
			next_tod_armed = i_tod_recur;
			next_tod_target = tod_target + tod_delta;
		end
		if (i_sub_arm) begin
			next_sub_period = i_sub_period;
			next_sub_count = i_sub_period;
			next_sub_armed = i_sub_period != 32'h0000_0000;
		end else if (tb.tick && sub_armed) begin
			if (sub_hit) begin
				next_sub_armed = i_sub_recur;
				next_sub_count = sub_period;
			end else begin
				next_sub_count = sub_count - 32'h0000_0001;
			end
		end
		// A hit in the clear cycle keeps its flag set.
		if (i_alarm_clear) begin
			next_tod_flag = 1'b0;
			next_sub_flag = 1'b0;
		end
		if (tod_hit) begin
			next_tod_flag = 1'b1;
		end
		if (sub_hit) begin
			next_sub_flag = 1'b1;
		end
		next_irq = (next_tod_flag & i_tod_int_en) | (next_sub_flag & i_sub_int_en);
		// The wake level is the only thing the power manager watches in any low-power mode.
		next_wake = (next_tod_flag & i_tod_wake_en) | (next_sub_flag & i_sub_wake_en);
		next_sqw = i_sqw_en & tb.sqw;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			seconds <= SEC_RESET;
			subsec <= '0;
			tod_target <= '0;
			tod_delta <= '0;
			tod_armed <= 1'b0;
			sub_count <= '0;
			sub_period <= '0;
			sub_armed <= 1'b0;
			tod_flag <= 1'b0;
			sub_flag <= 1'b0;
			irq <= 1'b0;
			wake <= 1'b0;
			sqw <= 1'b0;
			tod_reject <= 1'b0;
		end else begin
			seconds <= next_seconds;
			subsec <= next_subsec;
			tod_target <= next_tod_target;
			tod_delta <= next_tod_delta;
			tod_armed <= next_tod_armed;
			sub_count <= next_sub_count;
			sub_period <= next_sub_period;
			sub_armed <= next_sub_armed;
			tod_flag <= next_tod_flag;
			sub_flag <= next_sub_flag;
			irq <= next_irq;
			wake <= next_wake;
			sqw <= next_sqw;
			tod_reject <= next_tod_reject;
		end
	end

	assign o_seconds = seconds;
	assign o_subsec = subsec;
	assign o_tod_flag = tod_flag;
	assign o_sub_flag = sub_flag;
	assign o_irq = irq;
	assign o_wake = wake;
	assign o_square_wave_out = sqw;
	assign o_tod_reject = tod_reject;

	property p_sec_step;
		@(posedge i_clk) disable iff (i_rst)
		(sec_step && !i_sec_load) |=> seconds == $past(seconds) + 32'h0000_0001;
	endproperty
	a_sec_step: assert property (p_sec_step) else $error("seconds did not step");

	property p_sec_hold;
		@(posedge i_clk) disable iff (i_rst)
		(!sec_step && !i_sec_load) |=> $stable(seconds);
	endproperty
	a_sec_hold: assert property (p_sec_hold) else $error("seconds moved without wrap");

	property p_tod_range;
		@(posedge i_clk) disable iff (i_rst)
		(i_tod_arm && !delta_ok(i_tod_delta)) |=> o_tod_reject && $stable(tod_target);
	endproperty
	a_tod_range: assert property (p_tod_range) else $error("bad alarm delta accepted");

	property p_sub_tick;
		@(posedge i_clk) disable iff (i_rst)
		tb.tick |=> subsec == $past(subsec) + 12'h001 || $past(i_sec_load);
	endproperty
	a_sub_tick: assert property (p_sub_tick) else $error("subsecond missed a tick");

	sequence s_sub_hit;
		sub_hit && !i_sub_arm;
	endsequence
	property p_sub_recur;
		@(posedge i_clk) disable iff (i_rst)
		s_sub_hit |=> sub_armed == $past(i_sub_recur) && sub_count == sub_period;
	endproperty
	a_sub_recur: assert property (p_sub_recur) else $error("sub alarm rearm wrong");

	sequence s_tod_hit;
		tod_hit && !i_tod_arm;
	endsequence
	property p_tod_recur;
		@(posedge i_clk) disable iff (i_rst)
		s_tod_hit |=> tod_armed == $past(i_tod_recur)
			&& tod_target == $past(tod_target) + $past(tod_delta);
	endproperty
	a_tod_recur: assert property (p_tod_recur) else $error("tod alarm rearm wrong");

	property p_irq;
		@(posedge i_clk) disable iff (i_rst)
		tod_hit && i_tod_int_en |=> o_tod_flag && o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("alarm gave no interrupt");

	property p_wake;
		@(posedge i_clk) disable iff (i_rst)
		sub_hit && i_sub_wake_en |=> o_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("alarm gave no wake");

	property p_sqw_off;
		@(posedge i_clk) disable iff (i_rst)
		!i_sqw_en |=> !o_square_wave_out;
	endproperty
	a_sqw_off: assert property (p_sqw_off) else $error("square wave while disabled");

	property p_tick_spacing;
		@(posedge i_clk) disable iff (i_rst)
		tb.tick |=> !tb.tick [*2];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");
endmodule

// File: src/rtc_timebase.sv
// Time base prescaler: turns synchronised 32.768 kHz edges into 4096 Hz ticks with trim.
// Assumes the edge input is already synchronised to i_clk.
module rtc_timebase
	import rtc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_edge,
	input wire logic signed [TRIM_BITS-1:0] i_trim_ppm,
	rtc_tick_if.src tb
);
	logic [PRESCALE_BITS-1:0] div, next_div;
	logic [19:0] ppm, next_ppm;
	logic [6:0] skip, next_skip;
	logic [6:0] add, next_add;
	logic tick, next_tick;
	logic signed [TRIM_BITS-1:0] trim_c;

	// Trim is clamped to the documented range so that -128 cannot slip through.
	always_comb begin
		trim_c = i_trim_ppm;
		if (i_trim_ppm < -$signed(8'(TRIM_MAX_PPM))) begin
			trim_c = -$signed(8'(TRIM_MAX_PPM));
		end
	end

	// Each million edges, |trim| edges are dropped (slow) or counted twice (fast).
	always_comb begin
		next_div = div;
		next_ppm = ppm;
		next_skip = skip;
		next_add = add;
		next_tick = 1'b0;
		if (i_edge) begin
			if (ppm == PPM_PERIOD_LAST) begin
				next_ppm = '0;
				next_skip = (trim_c < 0) ? 7'(-trim_c) : 7'h00;
				next_add = (trim_c > 0) ? 7'(trim_c) : 7'h00;
			end else begin
				next_ppm = ppm + 20'h0_0001;
			end
			if (skip != 7'h00) begin
				next_skip = skip - 7'h01;
			end else begin
				if (div == PRESCALE_LAST || (add != 7'h00 && div == PRESCALE_LAST - 3'h1)) begin
					next_div = '0;
					next_tick = 1'b1;
					if (div != PRESCALE_LAST) begin
						next_add = add - 7'h01;
					end
				end else begin
					next_div = div + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div <= '0;
			ppm <= '0;
			skip <= '0;
			add <= '0;
			tick <= 1'b0;
		end else begin
			div <= next_div;
			ppm <= next_ppm;
			skip <= next_skip;
			add <= next_add;
			tick <= next_tick;
		end
	end

	assign tb.tick = tick;
	assign tb.sqw = div[PRESCALE_BITS-1];
endmodule

// File: testbench/rtc_clock_source.sv
// Model of the crystal and external time base sources, sped up so a second fits a short run.
// Assumes the block synchronises both pins; a stopped source parks its pin low.
module rtc_clock_source #(
	parameter int HALF_NS = 6
) (
	input wire logic i_run_xtal,
	input wire logic i_run_ext,
	output logic o_xtal_clk,
	output logic o_ext_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_xtal_clk = 1'b0;
		#1;
		forever begin
			#(HALF_NS);
			o_xtal_clk = i_run_xtal ? ~o_xtal_clk : 1'b0;
		end
	end
	// The external source runs at the same rate but with an unrelated phase.
	initial begin
		o_ext_clk = 1'b0;
		#3.5;
		forever begin
			#(HALF_NS);
			o_ext_clk = i_run_ext ? ~o_ext_clk : 1'b0;
		end
	end
endmodule

// File: testbench/rtc_seconds_alarm_unit_test.sv
// Self-checking bench for the seconds and alarm unit.
// Assumes a time base pin period of 12 ns, so one tick is 24 clocks and one second 98304.
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
	$display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module rtc_seconds_alarm_unit_test;
	timeunit 1ns;
	timeprecision 100ps;
	import rtc_pkg::*;
	int err_count = 0;
	int comparisons = 0;
	logic i_clk, i_rst, xtal, ext, run_xtal, run_ext, enable, sec_load, tod_arm, sub_arm;
	logic sub_recur, sub_int_en, sub_wake_en, tod_wake_en, alarm_clear, sqw_en, tod_recur, tod_int_en;
	logic tod_flag, sub_flag, irq, wake, sqw, reject, seen0, seen1;
	src_e src_sel;
	sec_t sec_value;
	logic [31:0] tod_delta, sub_period, seconds;
	logic [11:0] subsec, start;
	rtc_clock_source src (.i_run_xtal(run_xtal), .i_run_ext(run_ext), .o_xtal_clk(xtal),
		.o_ext_clk(ext));
	rtc_seconds_alarm_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_xtal_clk(xtal),
		.i_ext_clk(ext), .i_src_sel(src_sel), .i_enable(enable), .i_trim_ppm(8'h00),
		.i_sec_load(sec_load), .i_sec_value(sec_value), .i_tod_arm(tod_arm),
		.i_tod_delta(tod_delta), .i_tod_recur(tod_recur), .i_tod_int_en(tod_int_en),
		.i_tod_wake_en(tod_wake_en), .i_sub_arm(sub_arm), .i_sub_period(sub_period),
		.i_sub_recur(sub_recur), .i_sub_int_en(sub_int_en), .i_sub_wake_en(sub_wake_en),
		.i_alarm_clear(alarm_clear), .i_sqw_en(sqw_en), .o_seconds(seconds),
		.o_subsec(subsec), .o_tod_flag(tod_flag), .o_sub_flag(sub_flag), .o_irq(irq),
		.o_wake(wake), .o_square_wave_out(sqw), .o_tod_reject(reject));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic give_up(input string what);
		err_count++;
		$display("MISMATCH %s expected event seen timeout", what);
		wrap_up();
	endtask
	// Outputs are read just after an edge, so they show what the previous cycle settled.
	task automatic wait_tick(output logic [11:0] now);
		int n;
		now = subsec;
		for (n = 0; n < 100 && subsec === now; n++) @(posedge i_clk);
		if (n == 100) give_up("subsec");
		now = subsec;
	endtask
	task automatic t_idle();
		`CHK("seconds", 32'h0000_0000, seconds)
		`CHK("flags", 4'h0, {tod_flag, sub_flag, irq, wake})
		$display("test idle done");
	endtask
	task automatic t_sqw();
		seen0 = 1'b0;
		seen1 = 1'b0;
		repeat (64) @(posedge i_clk) seen1 |= sqw;
		`CHK("sqw off", 1'b0, seen1)
		sqw_en <= 1'b1;
		repeat (64) @(posedge i_clk) begin
			seen1 |= sqw;
			seen0 |= ~sqw;
		end
		`CHK("sqw on", 2'h3, {seen0, seen1})
		$display("test square wave done");
	endtask
	task automatic t_source();
		wait_tick(start);
		enable <= 1'b0;
		src_sel <= SRC_EXTERNAL;
		repeat (4) @(posedge i_clk);
		start = subsec;
		repeat (100) @(posedge i_clk);
		`CHK("disabled", start, subsec)
		enable <= 1'b1;
		repeat (100) @(posedge i_clk);
		`CHK("ext stopped", start, subsec)
		run_ext <= 1'b1;
		wait_tick(start);
		src_sel <= SRC_CRYSTAL;
		run_ext <= 1'b0;
		$display("test source done");
	endtask
	task automatic t_sub();
		int n;
		wait_tick(start);
		sub_arm <= 1'b1;
		@(posedge i_clk) sub_arm <= 1'b0;
		for (n = 0; n < 200 && sub_flag !== 1'b1; n++) @(posedge i_clk);
		if (n == 200) give_up("sub flag");
		`CHK("sub hit", start + 12'h003, subsec)
		`CHK("sub out", 2'h2, {irq, wake})
		sub_wake_en <= 1'b1;
		alarm_clear <= 1'b1;
		@(posedge i_clk) alarm_clear <= 1'b0;
		@(posedge i_clk);
		`CHK("cleared", 1'b0, sub_flag)
		for (n = 0; n < 200 && sub_flag !== 1'b1; n++) @(posedge i_clk);
		if (n == 200) give_up("sub recur flag");
		`CHK("recur", 2'h3, {sub_flag, wake})
		sub_period <= 32'h0000_0000;
		sub_arm <= 1'b1;
		alarm_clear <= 1'b1;
		@(posedge i_clk) sub_arm <= 1'b0;
		alarm_clear <= 1'b0;
		repeat (200) @(posedge i_clk);
		`CHK("disarmed", 1'b0, sub_flag)
		$display("test sub alarm done");
	endtask
	task automatic t_reject();
		logic [31:0] deltas [3] = '{32'h0000_0000, 32'h000f_d201, 32'h000f_d200};
		logic bad [3] = '{1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 3; i++) begin
			seen1 = 1'b0;
			tod_delta <= deltas[i];
			tod_arm <= 1'b1;
			@(posedge i_clk) tod_arm <= 1'b0;
			repeat (3) @(posedge i_clk) seen1 |= reject;
			`CHK("reject", bad[i], seen1)
		end
		$display("test reject done");
	endtask
	task automatic t_tod();
		int n;
		tod_int_en <= 1'b1;
		tod_recur <= 1'b1;
		sec_value <= 32'hffff_fffe;
		sec_load <= 1'b1;
		@(posedge i_clk) sec_load <= 1'b0;
		tod_delta <= 32'h0000_0001;
		tod_arm <= 1'b1;
		@(posedge i_clk) tod_arm <= 1'b0;
		for (n = 0; n < 100000 && seconds === 32'hffff_fffe; n++) @(posedge i_clk);
		if (n == 100000) give_up("seconds");
		`CHK("second", 32'hffff_ffff, seconds)
		`CHK("wrap", 12'h000, subsec)
		`CHK("tod hit", 3'h7, {tod_flag, wake, irq})
		$display("test tod alarm done");
	endtask
	initial begin
		{i_rst, run_xtal} = 2'h3;
		{run_ext, sec_load, tod_arm, sub_arm, alarm_clear, sqw_en, sub_wake_en} = 7'h00;
		{tod_recur, tod_int_en} = 2'h0;
		{enable, sub_recur, sub_int_en, tod_wake_en} = 4'hf;
		src_sel = SRC_CRYSTAL;
		sec_value = 32'h0000_0000;
		tod_delta = 32'h0000_0000;
		sub_period = 32'h0000_0003;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_idle();
		t_sqw();
		t_source();
		t_sub();
		t_reject();
		t_tod();
		wrap_up();
	end
endmodule
